// >>> design/range_mover_map.vh
// Register offsets, field layouts and limits of the marker range mover.
`ifndef RANGE_MOVER_MAP_VH
`define RANGE_MOVER_MAP_VH

// Number of mover instances and the size of the byte-addressed marker memory.
`define INSTANCES 32
`define INST_BITS 5
`define MEM_BYTES 17'h00180
`define MEM_ABITS 9
`define COUNT_MIN 16'h0001
`define COUNT_MAX 16'h017F

// Direct marker references: highest marker number of each kind and bytes per marker.
`define DIRECT_MAX 16'h0060
`define BYTE_AREA 17'h00060
`define WORD_AREA 17'h000C0
`define DWORD_AREA 17'h00180
`define WORD_BYTES 17'h00002
`define DWORD_BYTES 17'h00004

// Start operand layout: kind in the top two bits, value in the low sixteen.
`define OP_BITS 18
`define KIND_HI 17
`define KIND_LO 16
`define VAL_HI 15
`define KIND_OFFSET 2'h0
`define KIND_BYTE 2'h1
`define KIND_WORD 2'h2
`define KIND_DWORD 2'h3

// Register byte offsets.
`define OFS_SELECT 12'h000
`define OFS_MODE 12'h004
`define OFS_SOURCE 12'h008
`define OFS_DEST 12'h00C
`define OFS_COUNT 12'h010
`define OFS_OOR 12'h014
`define OFS_OVERLAP 12'h018
`define OFS_BADOFS 12'h01C
`define OFS_STATUS 12'h020
`define OFS_MASK 12'h024
`define OFS_PENDING 12'h028
`define OFS_MEM_BASE 12'h800

// Interrupt status bits.
`define ST_BITS 2
`define ST_DONE 0
`define ST_REFUSED 1

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> design/marker_ram.v
// Byte-wide marker memory with one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
module marker_ram (
	input wire clock, // System clock.
	input wire reset, // Clears the read register only.
	input wire we, // Write strobe.
	input wire [8:0] waddr, // Write byte address.
	input wire [7:0] wdata, // Write byte.
	input wire [8:0] raddr, // Read byte address.
	output reg [7:0] rdata // Byte read, one cycle after its address.
);
	reg [7:0] mem [0:383];

	always @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// >>> design/range_mover.v
// Marker range mover: 32 fill/copy instances sharing one byte engine, AXI4-Lite registers.
//
// Behaviour
// - Thirty-two independent mover instances over byte, word and double-word marker areas.
// - An instance moves data only on a rising trigger edge, never on level.
// - Mode bit selects fill or copy per instance; after reset all are fill.
// - Byte count gives destination bytes written; only 1 to 383 accepted.
// - Start and count inputs take any numeric value supplied by software.
// - Direct marker reference starts at that marker's own byte position.
// - Numeric start is a byte offset from the first marker byte.
// - Offset addressing reaches the whole marker memory; checks cover all of it.
// - Out-of-range flag when source or destination span leaves its area.
// - Overlap flag when source and destination spans share any byte.
// - No destination byte is written by a transfer whose own instance has an error in err_now, the unregistered flag value, when it is taken.
// - Error flags are evaluated continuously, independent of the trigger.
// - Fill mode: one source byte written to every destination byte.
// - Transfers are in bytes; multi-byte markers least significant byte first.
// - Copy mode: source bytes copied in order to matching destination bytes.
`timescale 1ns/1ps
`default_nettype none
`include "range_mover_map.vh"
module range_mover (
	input wire clock, // 20 MHz system clock.
	input wire reset, // Asynchronous reset, active high.
	input wire [31:0] trigger_coil, // Trigger level per instance, asynchronous.
	input wire [11:0] awaddr, // AXI write address.
	input wire awvalid, // AXI write address valid.
	output wire awready, // AXI write address ready.
	input wire [31:0] wdata, // AXI write data.
	input wire [3:0] wstrb, // AXI write strobes.
	input wire wvalid, // AXI write data valid.
	output wire wready, // AXI write data ready.
	output reg [1:0] bresp, // AXI write response.
	output reg bvalid, // AXI write response valid.
	input wire bready, // AXI write response ready.
	input wire [11:0] araddr, // AXI read address.
	input wire arvalid, // AXI read address valid.
	output wire arready, // AXI read address ready.
	output reg [31:0] rdata, // AXI read data.
	output reg [1:0] rresp, // AXI read response.
	output reg rvalid, // AXI read data valid.
	input wire rready, // AXI read data ready.
	output reg [31:0] out_of_range_flag, // Span leaves its area, per instance.
	output reg [31:0] overlap_flag, // Spans share a byte, per instance.
	output reg [31:0] bad_offset_flag, // Start or count invalid, per instance.
	output wire irq // Level interrupt.
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	integer i;
	integer j;

	////////////////////////////////////////////////////////////////////////////////
	// Start operand decoding.

	// Byte position of a start operand relative to the first marker byte.
	function [16:0] start_of;
		input [17:0] op;
		reg [16:0] num;
		begin
			num = {1'b0, op[`VAL_HI:0]} - 17'h00001;
			case (op[`KIND_HI:`KIND_LO])
				`KIND_OFFSET: start_of = {1'b0, op[`VAL_HI:0]};
				`KIND_BYTE: start_of = num;
				`KIND_WORD: start_of = num * `WORD_BYTES;
				`KIND_DWORD: start_of = num * `DWORD_BYTES;
				default: start_of = num;
			endcase
		end
	endfunction

	// End of the area that a span starting from this kind of operand may use.
	function [16:0] limit_of;
		input [1:0] kind;
		begin
			case (kind)
				`KIND_BYTE: limit_of = `BYTE_AREA;
				`KIND_WORD: limit_of = `WORD_AREA;
				`KIND_DWORD: limit_of = `DWORD_AREA;
				default: limit_of = `MEM_BYTES;
			endcase
		end
	endfunction

	// Start operand that points outside anything addressable.
	function bad_start;
		input [17:0] op;
		begin
			if (op[`KIND_HI:`KIND_LO] == `KIND_OFFSET) begin
				bad_start = ({1'b0, op[`VAL_HI:0]} >= `MEM_BYTES);
			end else begin
				bad_start = (op[`VAL_HI:0] == 16'h0000) || (op[`VAL_HI:0] > `DIRECT_MAX);
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Per-instance configuration and continuous error evaluation.

	reg [4:0] select_r;
	reg [31:0] mode_r;
	reg [17:0] src_r [0:31];
	reg [17:0] dst_r [0:31];
	reg [15:0] cnt_r [0:31];
	wire [31:0] oor_nxt;
	wire [31:0] ovl_nxt;
	wire [31:0] bad_nxt;

	genvar g;
	generate
		for (g = 0; g < `INSTANCES; g = g + 1) begin : inst
			wire [16:0] s = start_of(src_r[g]);
			wire [16:0] d = start_of(dst_r[g]);
			wire [16:0] n = {1'b0, cnt_r[g]};
			wire [16:0] sl = mode_r[g] ? n : 17'h00001;
			assign oor_nxt[g] = (s + sl > limit_of(src_r[g][`KIND_HI:`KIND_LO]))
				|| (d + n > limit_of(dst_r[g][`KIND_HI:`KIND_LO]));
			assign ovl_nxt[g] = (s < d + n) && (d < s + sl);
			assign bad_nxt[g] = bad_start(src_r[g]) || bad_start(dst_r[g])
				|| (cnt_r[g] < `COUNT_MIN) || (cnt_r[g] > `COUNT_MAX);
		end
	endgenerate

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			out_of_range_flag <= 32'h00000000;
			overlap_flag <= 32'h00000000;
			bad_offset_flag <= 32'h00000000;
		end else begin
			out_of_range_flag <= oor_nxt;
			overlap_flag <= ovl_nxt;
			bad_offset_flag <= bad_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger synchronisers and edge detection.

	reg [31:0] t1_r;
	reg [31:0] t2_r;
	reg [31:0] t3_r;
	reg [31:0] level_r;
	reg [31:0] pend_r;
	reg [31:0] take_mask;
	wire [31:0] agree = ~(t2_r ^ t3_r);
	wire [31:0] rise = agree & t2_r & ~level_r;

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			t1_r <= 32'h00000000;
			t2_r <= 32'h00000000;
			t3_r <= 32'h00000000;
			level_r <= 32'h00000000;
			pend_r <= 32'h00000000;
		end else begin
			t1_r <= trigger_coil;
			t2_r <= t1_r;
			t3_r <= t2_r;
			level_r <= (agree & t2_r) | (~agree & level_r);
			pend_r <= (pend_r & ~take_mask) | rise;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte engine.

	reg state_r;
	reg [4:0] pick;
	reg found;
	reg [16:0] e_src_r;
	reg [16:0] e_dst_r;
	reg [16:0] e_cnt_r;
	reg e_copy_r;
	reg [16:0] idx_r;
	reg wv_r;
	reg [8:0] wa_r;
	reg ev_done;
	reg ev_refused;
	wire [7:0] mem_rdata;
	wire [31:0] err_now = oor_nxt | ovl_nxt | bad_nxt;

	// Lowest pending instance is served first.
	always @* begin
		pick = 5'h00;
		found = 1'b0;
		take_mask = 32'h00000000;
		for (i = `INSTANCES - 1; i >= 0; i = i - 1) begin
			if (pend_r[i]) begin
				pick = i[4:0];
				found = 1'b1;
			end
		end
		if (found && state_r == ST_IDLE) begin
			take_mask[pick] = 1'b1;
		end
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			e_src_r <= 17'h00000;
			e_dst_r <= 17'h00000;
			e_cnt_r <= 17'h00000;
			e_copy_r <= 1'b0;
			idx_r <= 17'h00000;
			wv_r <= 1'b0;
			wa_r <= 9'h000;
			ev_done <= 1'b0;
			ev_refused <= 1'b0;
		end else begin
			ev_done <= 1'b0;
			ev_refused <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					wv_r <= 1'b0;
					idx_r <= 17'h00000;
					if (found) begin
						if (err_now[pick]) begin
							ev_refused <= 1'b1;
						end else begin
							state_r <= ST_RUN;
						end
						e_src_r <= start_of(src_r[pick]);
						e_dst_r <= start_of(dst_r[pick]);
						e_cnt_r <= {1'b0, cnt_r[pick]};
						e_copy_r <= mode_r[pick];
					end
				end
				ST_RUN: begin
					if (idx_r < e_cnt_r) begin
						wv_r <= 1'b1;
						wa_r <= e_dst_r[8:0] + idx_r[8:0];
						idx_r <= idx_r + 17'h00001;
					end else begin
						wv_r <= 1'b0;
						state_r <= ST_IDLE;
						ev_done <= 1'b1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	wire [8:0] eng_raddr = e_copy_r ? (e_src_r[8:0] + idx_r[8:0]) : e_src_r[8:0];

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	wire idle = (state_r == ST_IDLE) && !wv_r;
	wire aw_mem = (awaddr >= `OFS_MEM_BASE);
	wire ar_mem = (araddr >= `OFS_MEM_BASE);
	// The window offset is taken in bytes first, then turned into a word index.
	wire [11:0] aw_ofs = awaddr - `OFS_MEM_BASE;
	wire [11:0] ar_ofs = araddr - `OFS_MEM_BASE;
	wire [9:0] aw_idx = aw_ofs[11:2];
	wire [9:0] ar_idx = ar_ofs[11:2];
	reg rmem_r;
	wire aw_mem_ok = aw_mem && ({7'h00, aw_idx} < `MEM_BYTES);
	wire ar_mem_ok = ar_mem && ({7'h00, ar_idx} < `MEM_BYTES);
	wire wr_go = awvalid && wvalid && !bvalid && (!aw_mem || idle);
	wire rd_go = arvalid && !rvalid && !rmem_r && (!ar_mem || (idle && !(wr_go && aw_mem)));
	wire wr_en = wr_go && (wstrb != 4'h0);
	reg [`ST_BITS-1:0] status_r;
	reg [`ST_BITS-1:0] mask_r;
	reg [31:0] rd_val;
	reg rd_ok;

	assign awready = wr_go;
	assign wready = wr_go;
	assign arready = rd_go;
	assign irq = |(status_r & mask_r);

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			select_r <= 5'h00;
			mode_r <= 32'h00000000;
			for (j = 0; j < `INSTANCES; j = j + 1) begin
				src_r[j] <= 18'h00000;
				dst_r[j] <= 18'h00000;
				cnt_r[j] <= 16'h0000;
			end
			status_r <= 2'h0;
			mask_r <= 2'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
		end else begin
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= `RESP_OKAY;
				if (aw_mem && !aw_mem_ok) begin
					bresp <= `RESP_SLVERR;
				end else if (!aw_mem) begin
					case (awaddr)
						`OFS_SELECT, `OFS_MODE, `OFS_SOURCE, `OFS_DEST, `OFS_COUNT,
						`OFS_OOR, `OFS_OVERLAP, `OFS_BADOFS, `OFS_STATUS, `OFS_MASK,
						`OFS_PENDING: bresp <= `RESP_OKAY;
						default: bresp <= `RESP_SLVERR;
					endcase
				end
			end
			if (wr_en) begin
				case (awaddr)
					`OFS_SELECT: select_r <= wdata[4:0];
					`OFS_MODE: mode_r <= wdata;
					`OFS_SOURCE: src_r[select_r] <= wdata[`OP_BITS-1:0];
					`OFS_DEST: dst_r[select_r] <= wdata[`OP_BITS-1:0];
					`OFS_COUNT: cnt_r[select_r] <= wdata[15:0];
					`OFS_MASK: mask_r <= wdata[`ST_BITS-1:0];
					default: mask_r <= mask_r;
				endcase
			end
			// Hardware events win over a simultaneous write-one-to-clear.
			status_r <= (status_r & ~((wr_en && awaddr == `OFS_STATUS) ?
				wdata[`ST_BITS-1:0] : 2'h0)) | {ev_refused, ev_done};
		end
	end

	always @* begin
		rd_ok = 1'b1;
		case (araddr)
			`OFS_SELECT: rd_val = {27'h0000000, select_r};
			`OFS_MODE: rd_val = mode_r;
			`OFS_SOURCE: rd_val = {14'h0000, src_r[select_r]};
			`OFS_DEST: rd_val = {14'h0000, dst_r[select_r]};
			`OFS_COUNT: rd_val = {16'h0000, cnt_r[select_r]};
			`OFS_OOR: rd_val = out_of_range_flag;
			`OFS_OVERLAP: rd_val = overlap_flag;
			`OFS_BADOFS: rd_val = bad_offset_flag;
			`OFS_STATUS: rd_val = {30'h00000000, status_r};
			`OFS_MASK: rd_val = {30'h00000000, mask_r};
			`OFS_PENDING: rd_val = pend_r;
			default: begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			rmem_r <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			rmem_r <= 1'b0;
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			if (rmem_r) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, mem_rdata};
				rresp <= `RESP_OKAY;
			end
			if (rd_go) begin
				if (ar_mem_ok) begin
					rmem_r <= 1'b1;
				end else begin
					rvalid <= 1'b1;
					rdata <= rd_val;
					rresp <= (rd_ok && !ar_mem) ? `RESP_OKAY : `RESP_SLVERR;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Marker memory; the engine owns it while running, the bus only when idle.

	marker_ram ram (
		.clock(clock),
		.reset(reset),
		.we(wv_r || (wr_en && aw_mem_ok)),
		.waddr(wv_r ? wa_r : aw_idx[8:0]),
		.wdata(wv_r ? mem_rdata : wdata[7:0]),
		.raddr(state_r == ST_RUN ? eng_raddr : ar_idx[8:0]),
		.rdata(mem_rdata)
	);
endmodule
`default_nettype wire

// >>> verif/range_mover_checker.sv
// Concurrent checks on the range mover's bus handshake and flag outputs.
`timescale 1ns/1ps
`default_nettype none
module range_mover_checker (
	input wire logic clock, // Clock.
	input wire logic reset, // Reset.
	input wire logic awvalid, // Write address valid.
	input wire logic awready, // Write address ready.
	input wire logic wvalid, // Write data valid.
	input wire logic wready, // Write data ready.
	input wire logic [1:0] bresp, // Write response.
	input wire logic bvalid, // Response valid.
	input wire logic bready, // Response ready.
	input wire logic arvalid, // Read address valid.
	input wire logic arready, // Read address ready.
	input wire logic [31:0] rdata, // Read data.
	input wire logic [1:0] rresp, // Read response.
	input wire logic rvalid, // Read data valid.
	input wire logic rready, // Read data ready.
	input wire logic [31:0] out_of_range_flag, // Range flags.
	input wire logic [31:0] overlap_flag, // Overlap flags.
	input wire logic [31:0] bad_offset_flag // Offset flags.
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Cycles since the last accepted write; flags may only move shortly after one.
	logic [2:0] since_wr;
	always @(posedge clock or posedge reset) begin
		if (reset)
			since_wr <= 3'h0;
		else if (awvalid && awready)
			since_wr <= 3'h0;
		else if (since_wr != 3'h7)
			since_wr <= since_wr + 3'h1;
	end
	a_write_answer: assert property (awvalid && awready |=> bvalid)
		else $error("write not answered");
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_bvalid_drops: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released");
	a_aw_w_pair: assert property (awready == wready)
		else $error("address and data taken apart");
	a_no_write_overlap: assert property (bvalid |-> !awready)
		else $error("second write taken");
	a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
		else $error("read not answered");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
		else $error("read data not held");
	a_no_read_overlap: assert property (rvalid |-> !arready)
		else $error("second read taken");
	a_flags_from_config: assert property (
		!$stable({out_of_range_flag, overlap_flag, bad_offset_flag}) |-> since_wr < 3'h4)
		else $error("flags moved without a configuration change");
endmodule
bind range_mover range_mover_checker range_mover_checker_i (.clock(clock), .reset(reset),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .out_of_range_flag(out_of_range_flag),
	.overlap_flag(overlap_flag), .bad_offset_flag(bad_offset_flag));
`default_nettype wire

// >>> verif/coil_source.sv
// Trigger source standing in for the relay inputs that drive the coils.
`timescale 1ns/1ps
`default_nettype none
module coil_source (
	input wire logic [31:0] level_req, // Levels the bench asks for.
	output wire logic [31:0] trigger_coil // Coil levels seen by the mover.
);
	// Coil levels move out of phase with the mover's clock.
	assign #13 trigger_coil = level_req;
endmodule
`default_nettype wire

// >>> verif/range_mover_test.sv
// Self-checking bench for the range mover through its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "range_mover_map.vh"
module range_mover_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [31:0] trig_req = 32'h0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire [31:0] trigger_coil, rdata, oor, ovl, bad;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] d_s;
	logic [1:0] r_s;
	logic [31:0] ts[6] = '{32'h1005F, 32'h1005F, 32'h0007D, 32'h10000, 32'h10000, 32'h0017F};
	logic [31:0] td[6] = '{32'h3005D, 32'h3005D, 32'h2003C, 32'h0000A, 32'h00180, 32'h00000};
	logic [31:0] tc[6] = '{32'h12, 32'h10, 32'h0C, 32'h0, 32'h1, 32'h17F};
	logic [2:0] te[6] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h5, 3'h0};
	logic [7:0] cb[4] = '{8'h44, 8'hBD, 8'hCB, 8'h03};
	always #25 clock = ~clock;
	range_mover range_mover_i (.clock(clock), .reset(reset), .trigger_coil(trigger_coil),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .out_of_range_flag(oor), .overlap_flag(ovl),
		.bad_offset_flag(bad), .irq(irq));
	coil_source coil_source_i (.level_req(trig_req), .trigger_coil(trigger_coil));
	task automatic complete_run;
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return awready;
			1: return bvalid;
			2: return arready;
			default: return rvalid;
		endcase
	endfunction
	// Waits at falling edges for a handshake, then passes the edge that takes it.
	task automatic wt(input int k);
		int i;
		i = 0;
		@(negedge clock);
		while (sig(k) !== 1'b1 && i < 300) begin
			@(negedge clock);
			i++;
		end
		d_s = rdata;
		r_s = (k == 1) ? bresp : rresp;
		if (i == 300) begin
			n_fail++;
			complete_run;
		end
		@(posedge clock);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wt(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wt(1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wt(2);
		arvalid <= 1'b0;
		wt(3);
		rready <= 1'b0;
	endtask
	function automatic logic [11:0] mb(input int b);
		return 12'h800 + 12'(4 * b);
	endfunction
	task automatic cfg(input logic [31:0] n, input logic [31:0] s, dd, c);
		wr(`OFS_SELECT, n);
		wr(`OFS_SOURCE, s);
		wr(`OFS_DEST, dd);
		wr(`OFS_COUNT, c);
	endtask
	task automatic flg(input int n, input logic [2:0] e);
		logic [2:0] f;
		rd(`OFS_OOR);
		f[2] = d_s[n];
		rd(`OFS_OVERLAP);
		f[1] = d_s[n];
		rd(`OFS_BADOFS);
		f[0] = d_s[n];
		chk("flags", f, e);
		chk("flag pins", {oor[n], ovl[n], bad[n]}, e);
	endtask
	task automatic wait_st(input int b);
		int i;
		i = 0;
		d_s = 32'h0;
		while (d_s[b] !== 1'b1 && i < 50) begin
			rd(`OFS_STATUS);
			i++;
		end
		if (i == 50) begin
			n_fail++;
			complete_run;
		end
	endtask
	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		rd(`OFS_MODE);
		chk("mode", d_s, 32'h0);
		rd(`OFS_BADOFS);
		chk("reset flags", d_s, 32'hFFFFFFFF);
		rd(12'h030);
		chk("read resp", r_s, `RESP_SLVERR);
		wr(12'h030, 32'h1);
		chk("write resp", r_s, `RESP_SLVERR);
		wr(`OFS_MASK, 32'h1);
		wr(mb(9), 32'h2D);
		wr(mb(324), 32'h0);
		cfg(32'h0, 32'h1000A, 32'h30050, 32'h8);
		flg(0, 3'h0);
		@(posedge clock);
		trig_req[0] <= 1'b1;
		wait_st(`ST_DONE);
		@(negedge clock);
		chk("irq", irq, 1'b1);
		for (int b = 0; b < 8; b++) begin
			rd(mb((80 - 1) * 4 + b));
			chk("fill", d_s, 32'h2D);
		end
		rd(mb(324));
		chk("fill end", d_s, 32'h0);
		wr(`OFS_STATUS, 32'h3);
		rd(`OFS_STATUS);
		chk("status", d_s, 32'h0);
		chk("irq", irq, 1'b0);
		wr(`OFS_MODE, 32'h2);
		for (int b = 0; b < 4; b++)
			wr(mb(14 + b), {24'h0, cb[b]});
		cfg(32'h1, 32'h0000E, 32'h00040, 32'h4);
		@(posedge clock);
		trig_req[1] <= 1'b1;
		wait_st(`ST_DONE);
		for (int b = 0; b < 4; b++) begin
			rd(mb(64 + b));
			chk("copy", d_s, {24'h0, cb[b]});
		end
		wr(`OFS_STATUS, 32'h1);
		wr(mb(14), 32'hEE);
		repeat (40) @(posedge clock);
		rd(mb(64));
		chk("held trigger", d_s, 32'h44);
		rd(`OFS_STATUS);
		chk("held status", d_s, 32'h0);
		for (int t = 0; t < 6; t++) begin
			cfg(32'h2, ts[t], td[t], tc[t]);
			flg(2, te[t]);
		end
		cfg(32'h2, ts[2], td[2], tc[2]);
		wr(mb(118), 32'h77);
		@(posedge clock);
		trig_req[2] <= 1'b1;
		wait_st(`ST_REFUSED);
		rd(mb(118));
		chk("refused", d_s, 32'h77);
		@(negedge clock);
		chk("masked irq", irq, 1'b0);
		complete_run;
	end
endmodule
`default_nettype wire
